// ---- logic/vsf_pkg.sv ----
// package: register map, field positions, reset values and sizes
package vsf_pkg;
	// register offsets on the serial register port
	localparam logic [7:0] ADDR_DATA = 8'hb0; // fifo read data
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'hc0;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hc1;
	localparam logic [7:0] ADDR_CFG_DATA = 8'hc3;
	localparam logic [7:0] ADDR_CFG_ADDR_LO = 8'hc4;
	localparam logic [7:0] ADDR_CFG_ADDR_HI = 8'hc5;
	localparam logic [7:0] ADDR_STATUS = 8'hc6;
	localparam logic [7:0] ADDR_WORD_COUNT = 8'hc7;
	localparam logic [7:0] ADDR_THRESHOLD = 8'hc8;
	localparam logic [7:0] ADDR_FLUSH = 8'hc9;
	localparam logic [7:0] ADDR_LINE_IRQ = 8'hca;
	localparam logic [7:0] ADDR_SWITCH_LO = 8'hcb;
	localparam logic [7:0] ADDR_SWITCH_HI = 8'hcc;
	localparam logic [7:0] ADDR_OUT_CTRL = 8'hcd;
	// status field positions
	localparam int ST_OVERFLOW = 7;
	localparam int ST_EMPTY = 6;
	// interrupt status field positions
	localparam int IRQ_THRESH = 2;
	localparam int IRQ_LINE = 1;
	localparam int IRQ_DATA = 0;
	// line interrupt register fields
	localparam int LI_FIELD1_EN = 7;
	localparam int LI_FIELD2_EN = 6;
	// reset values
	localparam logic [7:0] RST_THRESHOLD = 8'h80;
	localparam logic [7:0] RST_LINE_IRQ = 8'h00;
	localparam logic [7:0] RST_SWITCH_LO = 8'h4e;
	localparam logic [7:0] RST_SWITCH_HI = 8'h00;
	localparam logic RST_HOST_ACCESS = 1'b1;
	// sizes
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 16;
	localparam int CFG_BYTES = 512;
	localparam int CFG_AW = 9;
	localparam int SERVICES = 6;
	localparam logic [5:0] LINE_MIN_VALID = 6'h02;
endpackage

// ---- logic/vsf_fifo.sv ----
// module: parameterised word fifo with valid/ready on both sides
`timescale 1ns/10ps
module vsf_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic [CW-1:0] o_count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH]; // storage
	logic [AW-1:0] wr_ptr_r; // write index
	logic [AW-1:0] rd_ptr_r; // read index
	logic [CW-1:0] count_r; // words held
	logic push;
	logic pop;

	assign o_in_ready = (count_r != CW'(DEPTH));
	assign o_out_valid = (count_r != '0);
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_count = count_r;
	assign o_out_data = mem_r[rd_ptr_r];

	// storage write, no reset needed on data
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= i_in_data;
		end
	end

	// pointers and count; flush wins over traffic
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || i_flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
			end
			if (pop) begin
				rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
			end
			if (push && !pop) begin
				count_r <= CW'(count_r + 1'b1);
			end else if (pop && !push) begin
				count_r <= CW'(count_r - 1'b1);
			end
		end
	end
endmodule

// ---- logic/vsf_top.sv ----
// module: sliced-data fifo, status, line and threshold interrupt control
//
// Functional notes
// - reads keep flags; write one clears
// - empty bit follows fifo state live
// - whole line not fitting sets overflow
// - later fitting line still written
// - six service availability flags, bits 5-0
// - word count register reports fifo words
// - count above threshold raises interrupt
// - any flush write empties fifo, clears data
// - line match interrupt, per-field enables
// - line values zero, one never interrupt
// - ten-bit switch pixel from sync edge
// - config memory 512 bytes, 32x16
// - interrupt bits clear on write one
// - fifo read by host or ancillary
`timescale 1ns/10ps
module vsf_top
	import vsf_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	// register port (decoded serial access)
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// slicer side: one line's words arrive as a burst
	input wire logic i_line_start,
	input wire logic [5:0] i_line_words,
	input wire logic i_word_valid,
	input wire logic [15:0] i_word_data,
	input wire logic i_line_done,
	input wire logic [SERVICES-1:0] i_service_done,
	output logic o_word_ready,
	// video timing from the decoder
	input wire logic [5:0] i_video_line,
	input wire logic i_line_begin,
	input wire logic i_field2,
	input wire logic [9:0] i_pixel_count,
	output logic o_standard_switch,
	// ancillary path and interrupt level
	output logic o_anc_valid,
	output logic [15:0] o_anc_data,
	input wire logic i_anc_ready,
	output logic o_irq
);
	logic [7:0] threshold_r; // word threshold
	logic [7:0] line_irq_r; // field enables and line number
	logic [7:0] switch_lo_r; // switch pixel low byte
	logic [1:0] switch_hi_r; // switch pixel bits 9:8
	logic host_access_r; // host reads fifo (else ancillary)
	logic [3:0] irq_en_r; // interrupt enables
	logic [2:0] irq_st_r; // latched thresh/line/data
	logic [SERVICES-1:0] avail_r; // service availability
	logic overflow_r; // fifo full error
	logic [CFG_AW-1:0] cfg_addr_r; // config memory pointer
	logic [7:0] cfg_mem_r [CFG_BYTES]; // configuration memory
	logic [7:0] cfg_rdata_r; // config read latch
	logic accept_r; // current line admitted
	logic [15:0] rd_word_r; // host-side holding word
	logic rd_byte_r; // which byte of word is next
	logic flush;
	logic wr_stat;
	logic wr_irq;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [15:0] fifo_out_data;
	logic [4:0] fifo_count;
	logic fits;
	logic thresh_hit;
	logic line_hit;
	logic host_pop;

	// any write to the flush address resets the fifo and data regs
	assign flush = i_reg_wr && (i_reg_addr == ADDR_FLUSH);
	assign wr_stat = i_reg_wr && (i_reg_addr == ADDR_STATUS);
	assign wr_irq = i_reg_wr && (i_reg_addr == ADDR_IRQ_STATUS);

	// room check uses the free words before the line starts
	assign fits = ({1'b0, i_line_words} <=
		7'(FIFO_DEPTH) - {2'b00, fifo_count});
	assign fifo_in_valid = i_word_valid && accept_r;
	// a refused line is drained and dropped, not stalled
	assign o_word_ready = accept_r ? fifo_in_ready : 1'b1;

	// host pops a word on the second byte read; else ancillary drains
	assign host_pop = i_reg_rd && (i_reg_addr == ADDR_DATA) && rd_byte_r;
	assign fifo_out_ready = host_access_r ? host_pop : i_anc_ready;
	assign o_anc_valid = !host_access_r && fifo_out_valid;
	assign o_anc_data = fifo_out_data;

	assign thresh_hit = {3'b000, fifo_count} > threshold_r;
	// line numbers 0 and 1 are rejected by the minimum
	assign line_hit = i_line_begin &&
		(i_video_line == line_irq_r[5:0]) &&
		(line_irq_r[5:0] >= LINE_MIN_VALID) &&
		(i_field2 ? line_irq_r[LI_FIELD2_EN]
			: line_irq_r[LI_FIELD1_EN]);
	// the slicer controller loads the next standard here
	assign o_standard_switch =
		(i_pixel_count == {switch_hi_r, switch_lo_r});
	assign o_irq = |(irq_st_r & irq_en_r[2:0]);

	vsf_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_flush(flush),
		.i_in_valid(fifo_in_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(i_word_data),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_out_ready),
		.o_out_data(fifo_out_data),
		.o_count(fifo_count)
	);

	// plain read-write configuration registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			threshold_r <= RST_THRESHOLD;
			line_irq_r <= RST_LINE_IRQ;
			switch_lo_r <= RST_SWITCH_LO;
			switch_hi_r <= RST_SWITCH_HI[1:0];
			host_access_r <= RST_HOST_ACCESS;
			irq_en_r <= 4'h0;
		end else if (i_reg_wr) begin
			if (i_reg_addr == ADDR_THRESHOLD) begin
				threshold_r <= i_reg_wdata;
			end else if (i_reg_addr == ADDR_LINE_IRQ) begin
				line_irq_r <= i_reg_wdata;
			end else if (i_reg_addr == ADDR_SWITCH_LO) begin
				switch_lo_r <= i_reg_wdata;
			end else if (i_reg_addr == ADDR_SWITCH_HI) begin
				switch_hi_r <= i_reg_wdata[1:0];
			end else if (i_reg_addr == ADDR_OUT_CTRL) begin
				host_access_r <= i_reg_wdata[0];
			end else if (i_reg_addr == ADDR_IRQ_ENABLE) begin
				irq_en_r <= i_reg_wdata[3:0];
			end
		end
	end

	// line admission decided once at line start: all or nothing
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || flush) begin
			accept_r <= 1'b0;
		end else if (i_line_start) begin
			accept_r <= fits;
		end else if (i_line_done) begin
			accept_r <= 1'b0;
		end
	end

	// overflow sticky; set beats a same-cycle clear
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			overflow_r <= 1'b0;
		end else if (i_line_start && !fits) begin
			overflow_r <= 1'b1;
		end else if (wr_stat && i_reg_wdata[ST_OVERFLOW]) begin
			overflow_r <= 1'b0;
		end
	end

	// availability flags; reads never touch them
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || flush) begin
			avail_r <= '0;
		end else begin
			for (int i = 0; i < SERVICES; i++) begin
				if (i_service_done[i]) begin
					avail_r[i] <= 1'b1;
				end else if (wr_stat && i_reg_wdata[i]) begin
					avail_r[i] <= 1'b0;
				end
			end
		end
	end

	// latched interrupt conditions, write one clears, set wins
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			irq_st_r <= 3'b000;
		end else begin
			if (thresh_hit) begin
				irq_st_r[IRQ_THRESH] <= 1'b1;
			end else if (wr_irq && i_reg_wdata[IRQ_THRESH]) begin
				irq_st_r[IRQ_THRESH] <= 1'b0;
			end
			if (line_hit) begin
				irq_st_r[IRQ_LINE] <= 1'b1;
			end else if (wr_irq && i_reg_wdata[IRQ_LINE]) begin
				irq_st_r[IRQ_LINE] <= 1'b0;
			end
			if (|i_service_done) begin
				irq_st_r[IRQ_DATA] <= 1'b1;
			end else if (wr_irq && i_reg_wdata[IRQ_DATA]) begin
				irq_st_r[IRQ_DATA] <= 1'b0;
			end
		end
	end

	// config memory: pointer auto-increments per data access
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cfg_addr_r <= '0;
		end else if (i_reg_wr && i_reg_addr == ADDR_CFG_ADDR_LO) begin
			cfg_addr_r[7:0] <= i_reg_wdata;
		end else if (i_reg_wr && i_reg_addr == ADDR_CFG_ADDR_HI) begin
			cfg_addr_r[8] <= i_reg_wdata[0];
		end else if ((i_reg_wr || i_reg_rd) &&
			i_reg_addr == ADDR_CFG_DATA) begin
			cfg_addr_r <= CFG_AW'(cfg_addr_r + 1'b1);
		end
	end

	// config storage; contents loaded by host, no reset on array
	always_ff @(posedge i_clk) begin
		if (i_reg_wr && i_reg_addr == ADDR_CFG_DATA) begin
			cfg_mem_r[cfg_addr_r] <= i_reg_wdata;
		end
		cfg_rdata_r <= cfg_mem_r[cfg_addr_r];
	end

	// host byte pairing: low byte first, word popped on high byte
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || flush || !host_access_r) begin
			rd_byte_r <= 1'b0;
			rd_word_r <= 16'h0000;
		end else if (i_reg_rd && i_reg_addr == ADDR_DATA &&
			fifo_out_valid) begin
			rd_byte_r <= !rd_byte_r;
			rd_word_r <= fifo_out_data;
		end
	end

	// read mux, registered; unmapped reads return zero
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_addr == ADDR_STATUS) begin
			o_reg_rdata <= {overflow_r, (fifo_count == 5'd0),
				avail_r};
		end else if (i_reg_addr == ADDR_WORD_COUNT) begin
			o_reg_rdata <= {3'b000, fifo_count};
		end else if (i_reg_addr == ADDR_THRESHOLD) begin
			o_reg_rdata <= threshold_r;
		end else if (i_reg_addr == ADDR_LINE_IRQ) begin
			o_reg_rdata <= line_irq_r;
		end else if (i_reg_addr == ADDR_SWITCH_LO) begin
			o_reg_rdata <= switch_lo_r;
		end else if (i_reg_addr == ADDR_SWITCH_HI) begin
			o_reg_rdata <= {6'b000000, switch_hi_r};
		end else if (i_reg_addr == ADDR_OUT_CTRL) begin
			o_reg_rdata <= {7'b0000000, host_access_r};
		end else if (i_reg_addr == ADDR_IRQ_STATUS) begin
			o_reg_rdata <= {5'b00000, irq_st_r};
		end else if (i_reg_addr == ADDR_IRQ_ENABLE) begin
			o_reg_rdata <= {4'h0, irq_en_r};
		end else if (i_reg_addr == ADDR_CFG_DATA) begin
			o_reg_rdata <= cfg_rdata_r;
		end else if (i_reg_addr == ADDR_DATA) begin
			// byte order: low then high of the head word
			o_reg_rdata <= rd_byte_r ? rd_word_r[15:8]
				: fifo_out_data[7:0];
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end
endmodule

// ---- sim/vsf_properties.sv ----
// checker: port-level properties of the sliced-data block
`timescale 1ns/10ps
module vsf_props
	import vsf_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_line_start,
	input wire logic i_word_valid,
	input wire logic [9:0] i_pixel_count,
	input wire logic o_standard_switch,
	input wire logic o_irq
);
	logic [9:0] sw_r; // shadow of the switch pixel
	logic [2:0] en_r; // shadow of the interrupt enables
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// shadows follow host writes, so no design internals are needed
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sw_r <= {RST_SWITCH_HI[1:0], RST_SWITCH_LO};
			en_r <= 3'h0;
		end else if (i_reg_wr) begin
			if (i_reg_addr == ADDR_SWITCH_LO) sw_r[7:0] <= i_reg_wdata;
			if (i_reg_addr == ADDR_SWITCH_HI) sw_r[9:8] <= i_reg_wdata[1:0];
			if (i_reg_addr == ADDR_IRQ_ENABLE) en_r <= i_reg_wdata[2:0];
		end
	end
	// flush write followed by a quiet cycle
	sequence s_flush;
		i_reg_wr && i_reg_addr == ADDR_FLUSH && !i_word_valid ##1
			!i_word_valid && !i_reg_wr && !i_line_start;
	endsequence
	// no traffic and no host write
	sequence s_quiet;
		!i_word_valid && !i_reg_wr && !i_line_start;
	endsequence
	a_reset_idle: assert property (
		disable iff (1'b0) !i_rst_n |=> o_reg_rdata == 8'h00 && !o_irq)
		else $error("outputs busy after reset");
	a_unmapped_zero: assert property (
		i_reg_addr < ADDR_DATA |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_flush_count: assert property (
		s_flush ##1 (i_reg_addr == ADDR_WORD_COUNT && !i_word_valid)
		|=> o_reg_rdata == 8'h00) else $error("count after flush");
	a_flush_empty: assert property (
		s_flush ##1 s_quiet[*4] ##0 i_reg_addr == ADDR_STATUS
		|=> o_reg_rdata[ST_EMPTY]) else $error("empty after flush");
	a_flags_sticky: assert property (
		(i_reg_addr == ADDR_STATUS && !i_reg_wr) ##1 !i_reg_wr ##1
		i_reg_addr == ADDR_STATUS
		|=> ($past(o_reg_rdata, 2) & ~o_reg_rdata & 8'hbf) == 8'h00)
		else $error("flag fell without a write");
	a_switch_hit: assert property (
		i_pixel_count == sw_r |-> o_standard_switch)
		else $error("switch missing");
	a_switch_miss: assert property (
		i_pixel_count != sw_r |-> !o_standard_switch)
		else $error("switch spurious");
	a_irq_masked: assert property (
		en_r == 3'h0 |-> !o_irq) else $error("masked irq on pin");
endmodule

// ---- sim/vsf_host_model.sv ----
// host processor model on the decoded register port
`timescale 1ns/10ps
module vsf_host_model
	import vsf_pkg::*;
(
	input wire logic i_clk,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	// idle port; config entries are never rewritten here
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// one-cycle write strobe; address held afterwards
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk) begin o_wr <= 1'b1; o_addr <= a; o_wdata <= d; end
		@(posedge i_clk) o_wr <= 1'b0;
	endtask
	// read strobe; data follows one cycle later
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk) begin o_rd <= 1'b1; o_addr <= a; end
		@(posedge i_clk) o_rd <= 1'b0;
	endtask
	// caller picks a pixel past pipeline drain
	task automatic set_switch(input logic [9:0] p);
		wr(ADDR_SWITCH_LO, p[7:0]);
		wr(ADDR_SWITCH_HI, {6'h00, p[9:8]});
	endtask
endmodule

// ---- sim/vbi_data_fifo_status_control_bench.sv ----
// testbench: registers, fifo, interrupts and switch timing
`timescale 1ns/10ps
module vbi_data_fifo_status_control_bench
	import vsf_pkg::*;
;
	logic clk = '0, rst_n = '0, ls = '0, wv = '0, ld = '0, lb = '0, f2 = '0;
	logic ar = '0, rdd = '0, e, wr, rd, sw, av, irq, rdy;
	logic [5:0] lw = '0, svc = '0, vl = '0;
	logic [15:0] wd = '0, x, y, ad2;
	logic [15:0] fq[$], eq[$]; // words of kept lines, notes of expected reads
	logic [9:0] pc = '0, sp;
	logic [7:0] ad, wdt, rdata;
	logic [23:0] rv[8] = '{{ADDR_THRESHOLD, RST_THRESHOLD, 8'hff},
		{ADDR_LINE_IRQ, RST_LINE_IRQ, 8'hff},
		{ADDR_SWITCH_LO, RST_SWITCH_LO, 8'hff},
		{ADDR_SWITCH_HI, RST_SWITCH_HI, 8'h03}, {ADDR_STATUS, 8'h40, 8'hff},
		{ADDR_WORD_COUNT, 8'h00, 8'hff}, {8'h10, 8'h00, 8'hff},
		{ADDR_IRQ_STATUS, 8'h00, 8'h07}};
	logic [8:0] li[5] = '{9'h085, 9'h185, 9'h145, 9'h0c1, 9'h1c0};
	int error_cnt = 0, check_count = 0;
	vsf_host_model u_host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(ad),
		.o_wdata(wdt));
	vsf_top u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(ad), .i_reg_wdata(wdt),
		.o_reg_rdata(rdata), .i_line_start(ls), .i_line_words(lw),
		.i_word_valid(wv), .i_word_data(wd), .i_line_done(ld),
		.i_service_done(svc), .o_word_ready(rdy), .i_video_line(vl),
		.i_line_begin(lb), .i_field2(f2), .i_pixel_count(pc),
		.o_standard_switch(sw), .o_anc_valid(av), .o_anc_data(ad2),
		.i_anc_ready(ar), .o_irq(irq));
	always #10 clk = ~clk;
	// random stalls on the ancillary side
	always @(posedge clk) begin rdd <= rd; ar <= 1'($urandom); end
	task automatic bad(input string s);
		error_cnt++;
		$display("MISMATCH %0t %s", $time, s);
	endtask
	task automatic see(input logic v, input logic t, input string s);
		check_count++;
		if (v !== t) bad(s);
	endtask
	// oldest note is checked as each result appears
	always @(negedge clk) begin
		if (rdd) begin
			y = eq.pop_front();
			check_count++;
			if ((rdata & y[15:8]) !== y[7:0]) bad("read data");
		end
		if (av && ar) begin
			check_count++;
			if (ad2 !== fq.pop_front()) bad("ancillary word");
		end
	end
	task automatic chk(input logic [7:0] a, e0, m);
		eq.push_back({m, e0 & m});
		u_host.rd(a);
	endtask
	// one sliced line: start, words, done
	task automatic line(input int n, input bit keep);
		logic [15:0] w;
		@(posedge clk) begin ls <= 1'b1; lw <= 6'(n); end
		@(posedge clk) ls <= 1'b0;
		repeat (n) begin
			w = 16'($urandom);
			if (keep) fq.push_back(w);
			wv <= 1'b1;
			wd <= w;
			@(negedge clk);
			while (rdy !== 1'b1) @(negedge clk);
			@(posedge clk);
		end
		wv <= 1'b0;
		ld <= 1'b1;
		@(posedge clk) ld <= 1'b0;
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		bad("watchdog expired");
		finish_test();
	end
	initial begin
		void'($urandom(32'h60ba));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		u_host.wr(ADDR_WORD_COUNT, 8'h55);
		foreach (rv[i]) chk(rv[i][23:16], rv[i][15:8], rv[i][7:0]);
		$display("done reset values");
		line(12, 1);
		line(6, 0);
		line(2, 1);
		chk(ADDR_WORD_COUNT, 8'h0e, 8'hff);
		chk(ADDR_STATUS, 8'h80, 8'hc0);
		u_host.wr(ADDR_THRESHOLD, 8'h0d);
		u_host.wr(ADDR_IRQ_ENABLE, 8'h04);
		chk(ADDR_IRQ_STATUS, 8'h04, 8'h04);
		@(negedge clk) see(irq, 1'b1, "threshold irq");
		u_host.wr(ADDR_IRQ_ENABLE, 8'h00);
		@(negedge clk) see(irq, 1'b0, "masked irq");
		repeat (14) begin
			x = fq.pop_front();
			chk(ADDR_DATA, x[7:0], 8'hff);
			chk(ADDR_DATA, x[15:8], 8'hff);
		end
		chk(ADDR_STATUS, 8'h40, 8'h40);
		u_host.wr(ADDR_STATUS, 8'h80);
		chk(ADDR_STATUS, 8'h00, 8'h80);
		u_host.wr(ADDR_IRQ_STATUS, 8'h04);
		chk(ADDR_IRQ_STATUS, 8'h00, 8'h04);
		$display("done overflow and drain");
		for (int i = 0; i < SERVICES; i++) begin
			@(posedge clk) svc <= 6'(1 << i);
			@(posedge clk) svc <= '0;
			chk(ADDR_DATA, 8'h00, 8'h00);
			chk(ADDR_STATUS, 8'(1 << i), 8'h3f);
			u_host.wr(ADDR_STATUS, 8'(1 << i));
			chk(ADDR_STATUS, 8'h00, 8'(1 << i));
		end
		line(3, 0);
		@(posedge clk) svc <= 6'h3f;
		@(posedge clk) svc <= '0;
		u_host.wr(ADDR_FLUSH, 8'($urandom));
		chk(ADDR_WORD_COUNT, 8'h00, 8'hff);
		chk(ADDR_STATUS, 8'h40, 8'h7f);
		$display("done flags and flush");
		u_host.wr(ADDR_IRQ_ENABLE, 8'h02);
		foreach (li[i]) begin
			u_host.wr(ADDR_LINE_IRQ, li[i][7:0]);
			u_host.wr(ADDR_IRQ_STATUS, 8'h02);
			@(posedge clk) begin vl <= li[i][5:0]; f2 <= li[i][8]; lb <= 1'b1; end
			@(posedge clk) lb <= 1'b0;
			e = (li[i][5:0] > 6'h01) && (li[i][8] ? li[i][6] : li[i][7]);
			chk(ADDR_IRQ_STATUS, {6'h00, e, 1'b0}, 8'h02);
		end
		sp = 10'($urandom);
		u_host.set_switch(sp);
		@(posedge clk) pc <= sp;
		@(negedge clk) see(sw, 1'b1, "switch on match");
		@(posedge clk) pc <= sp + 10'h001;
		@(negedge clk) see(sw, 1'b0, "switch off match");
		// config memory: two bytes at 110h, pointer reloaded, read back
		u_host.wr(ADDR_CFG_ADDR_LO, 8'h10);
		u_host.wr(ADDR_CFG_ADDR_HI, 8'h01);
		u_host.wr(ADDR_CFG_DATA, 8'ha5);
		u_host.wr(ADDR_CFG_DATA, 8'h5a);
		u_host.wr(ADDR_CFG_ADDR_LO, 8'h10);
		chk(ADDR_CFG_DATA, 8'ha5, 8'hff);
		chk(ADDR_CFG_DATA, 8'h5a, 8'hff);
		u_host.wr(ADDR_OUT_CTRL, 8'h00);
		line(3, 1);
		repeat (200) if (fq.size() != 0) @(posedge clk);
		see(fq.size() == 0, 1'b1, "ancillary drain");
		u_host.wr(ADDR_OUT_CTRL, 8'h01);
		$display("done line irq, switch, ancillary");
		repeat (3) @(posedge clk);
		finish_test();
	end
endmodule
bind vsf_top vsf_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.o_reg_rdata(o_reg_rdata), .i_line_start(i_line_start),
	.i_word_valid(i_word_valid), .i_pixel_count(i_pixel_count),
	.o_standard_switch(o_standard_switch), .o_irq(o_irq));
